// *** include/apcr_pkg.sv ***
// Constants for the primary configuration register block.
// Assumes one 100 MHz clock; serial pins are sampled, not used as clocks.
package apcr_pkg;
  // Frame geometry
  localparam int FRAME_BITS     = 16;           // Plain register frame
  localparam int CRC_W          = 8;            // Width of a frame CRC
  localparam int CRC_FRAME_BITS = 24;           // Frame with CRC appended
  localparam int DATA_W         = 12;           // Data field of a frame
  localparam int COUNT_W        = 5;            // Bit counter width
  localparam int SYNC_STAGES    = 3;            // Pin synchroniser depth
  // Command field
  localparam int BIT_WR         = 15;           // Write flag
  localparam int ADDR_HI        = 14;           // Register select, top bit
  localparam int ADDR_LO        = 12;           // Register select, low bit
  localparam logic [2:0] REG_ADDR = 3'h1;       // This register's address
  // Field positions
  localparam int BIT_PAIR       = 11;           // Input pair select
  localparam int BIT_SEQ        = 10;           // Pair sequencer enable
  localparam int BIT_STYLE      = 9;            // Averaging style
  localparam int RATIO_HI       = 8;            // Averaging ratio, top bit
  localparam int RATIO_LO       = 6;            // Averaging ratio, low bit
  localparam int BIT_CRC_IN     = 5;            // Serial input CRC enable
  localparam int BIT_CRC_OUT    = 4;            // Serial output CRC enable
  localparam int RATIO_W        = 3;            // Ratio field width
  localparam logic [2:0] RATIO_MIN_ON = 3'h1;   // Lowest ratio code (2x)
  localparam logic [2:0] RATIO_MAX_ON = 3'h5;   // Highest ratio code (32x)
  // Reset and CRC defaults
  localparam logic [11:0] RESET_VALUE = 12'h000; // Stored fields at reset
  localparam logic [7:0]  CRC_INIT    = 8'h00;   // CRC seed
  localparam logic [7:0]  CRC_POLY_DEF = 8'h07;  // Default CRC polynomial

  // One serial step of the CRC shift register
  function automatic logic [7:0] apcr_crc_step(input logic [7:0] crc,
                                               input logic       bit_in,
                                               input logic [7:0] poly);
    apcr_crc_step = {crc[6:0], 1'b0} ^ ((crc[7] ^ bit_in) ? poly : 8'h00);
  endfunction
endpackage

// *** include/apcr_if.sv ***
// Link between the frame receiver and the register core.
// Assumes both ends run on mclk_i; every signal is a one-cycle pulse or held data.
`timescale 1ns/10ps
interface apcr_if;
  logic        sclk_fall;   // Serial clock falling edge seen
  logic        cs_fall;     // Frame (and conversion) start seen
  logic        frame_done;  // Frame ended, fields below valid
  logic [15:0] frame_word;  // Command and data of the frame
  logic [4:0]  frame_bits;  // Serial clock edges counted in the frame
  logic        crc_ok;      // Appended CRC matched the word
  modport rx   (output sclk_fall, cs_fall, frame_done, frame_word, frame_bits, crc_ok);
  modport core (input  sclk_fall, cs_fall, frame_done, frame_word, frame_bits, crc_ok);
endinterface

// *** rtl/apcr_frame_rx.sv ***
// Serial frame receiver: synchronises the pins and collects each frame.
// Assumes sclk_i, cs_n_i and sdi_i are slow against mclk_i (several cycles per level).
`timescale 1ns/10ps
module apcr_frame_rx #(
  parameter logic [7:0] CRC_POLY = apcr_pkg::CRC_POLY_DEF
) (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic sdi_i,
  apcr_if.rx        rx
);
  import apcr_pkg::*;

  typedef enum logic {APCR_IDLE, APCR_SHIFT} apcr_state_type;

  logic [2:0]         pins;     // Raw pins: sclk, cs_n, sdi
  logic [2:0]         filt;     // Filtered pin levels
  logic [2:0]         filt_d;   // Previous filtered levels
  apcr_state_type     state;    // Frame state
  logic [23:0]        shreg;    // Received bits, newest in bit 0
  logic [COUNT_W-1:0] count;    // Rising edges in this frame
  logic [7:0]         crc;      // CRC over the first 16 bits

  assign pins = {sclk_i, cs_n_i, sdi_i};

  // Three-stage synchroniser per pin; a level counts once stages two and three agree
  for (genvar g = 0; g < 3; g++) begin : g_sync
    logic [SYNC_STAGES-1:0] s;  // s[0] feeds s[1] only
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        s       <= {1'b0, 2'b11} & {SYNC_STAGES{g == 1}};
        filt[g] <= (g == 1);
      end else begin
        s <= {s[SYNC_STAGES-2:0], pins[g]};
        if (s[1] == s[2]) begin
          filt[g] <= s[2];
        end
      end
    end
  end

  // Edge history of filtered levels
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      filt_d <= 3'b010;
    end else begin
      filt_d <= filt;
    end
  end

  // Frame collection: shift on serial clock rising edge while selected
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state         <= APCR_IDLE;
      shreg         <= '0;
      count         <= '0;
      crc           <= CRC_INIT;
      rx.frame_done <= 1'b0;
      rx.frame_word <= '0;
      rx.frame_bits <= '0;
      rx.crc_ok     <= 1'b0;
    end else begin
      rx.frame_done <= 1'b0;
      case (state)
        APCR_IDLE: begin
          if (!filt[1] && filt_d[1]) begin  // Frame opens
            state <= APCR_SHIFT;
            count <= '0;
            crc   <= CRC_INIT;
          end
        end
        APCR_SHIFT: begin
          if (filt[1]) begin  // Frame closes, hand over its contents
            state         <= APCR_IDLE;
            rx.frame_done <= 1'b1;
            rx.frame_bits <= count;
            rx.frame_word <= (count == COUNT_W'(CRC_FRAME_BITS)) ? shreg[23:8]
                                                                   : shreg[15:0];
            rx.crc_ok     <= (count == COUNT_W'(CRC_FRAME_BITS)) && (shreg[7:0] == crc);
          end else if (filt[2] && !filt_d[2]) begin
            shreg <= {shreg[22:0], filt[0]};
            if (count != '1) begin
              count <= count + COUNT_W'(1);
            end
            if (count < COUNT_W'(FRAME_BITS)) begin
              crc <= apcr_crc_step(crc, filt[0], CRC_POLY);
            end
          end
        end
        default: state <= APCR_IDLE;
      endcase
    end
  end

  // Edge pulses for the core
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rx.sclk_fall <= 1'b0;
      rx.cs_fall   <= 1'b0;
    end else begin
      rx.sclk_fall <= !filt[2] && filt_d[2] && !filt[1];
      rx.cs_fall   <= !filt[1] && filt_d[1];
    end
  end

  default clocking cb_rx @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_frame_count: assert property (rx.frame_done |-> rx.frame_bits == $past(count))
    else $error("frame length not reported as counted");
  c_frame_crc: cover property (rx.frame_done && rx.frame_bits == 5'd24 && rx.crc_ok);
endmodule

// *** rtl/apcr_top.sv ***
// Primary configuration register of a dual sampling converter, serial access.
// Assumes a host driving 16-bit (or 24-bit with CRC) frames on sclk/cs_n/sdi.
`timescale 1ns/10ps
module apcr_top #(
  parameter logic [7:0] CRC_POLY = apcr_pkg::CRC_POLY_DEF
) (
  input  wire logic                          mclk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          sclk_i,
  input  wire logic                          cs_n_i,
  input  wire logic                          sdi_i,
  input  wire logic [apcr_pkg::FRAME_BITS-1:0] conv_a_i,
  input  wire logic [apcr_pkg::FRAME_BITS-1:0] conv_b_i,
  output logic                               first_data_output_o,
  output logic                               second_output_or_alert_o,
  output logic                               pair_select_o,
  output logic                               sequencer_active_o,
  output logic                               averaging_style_o,
  output logic [apcr_pkg::RATIO_W-1:0]       averaging_ratio_o,
  output logic                               oversample_on_o,
  output logic                               in_crc_enable_o,
  output logic                               out_crc_enable_o,
  output logic                               conv_start_o,
  output logic                               crc_reject_o
);
  import apcr_pkg::*;

  // Refuse a polynomial without its constant term
  if (CRC_POLY[0] != 1'b1) begin : g_check
    $error("CRC polynomial needs its lowest bit set");
  end

  apcr_if link ();  // Receiver to core link

  apcr_frame_rx #(
    .CRC_POLY (CRC_POLY)
  ) u_rx (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .sclk_i    (sclk_i),
    .cs_n_i    (cs_n_i),
    .sdi_i     (sdi_i),
    .rx        (link.rx)
  );

  logic [DATA_W-1:0] cfg;           // Stored fields, bits 11:0
  logic              read_pending;  // Next frame returns this register
  logic [23:0]       shift_a;       // First output shifter
  logic [23:0]       shift_b;       // Second output shifter
  logic [15:0]       readback;      // Register word as read back
  logic              is_write;      // Frame carries the write flag
  logic              hits_reg;      // Frame addresses this register
  logic              plain_len;     // Frame had 16 bits
  logic              crc_good;      // Frame had 24 bits and a matching CRC
  logic              need_crc;      // Frame must carry a valid CRC
  logic              accept;        // Frame may take effect
  logic              next_pair;     // Pair for the starting conversion

  // Readback places this register's address in the top nibble
  assign readback = {1'b0, REG_ADDR, cfg};

  // Command decode of the finished frame
  always_comb begin
    is_write  = link.frame_word[BIT_WR];
    hits_reg  = link.frame_word[ADDR_HI:ADDR_LO] == REG_ADDR;
    plain_len = link.frame_bits == 5'(FRAME_BITS);
    crc_good  = link.crc_ok;
    // Input CRC already on, or a write that would switch it on
    need_crc  = cfg[BIT_CRC_IN]
                || (is_write && hits_reg && link.frame_word[BIT_CRC_IN]);
    accept    = crc_good || (plain_len && !need_crc);
  end

  // Register write; rejected frames leave it untouched
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cfg <= RESET_VALUE;
    end else if (link.frame_done && accept && is_write && hits_reg) begin
      cfg <= link.frame_word[DATA_W-1:0];
    end
  end

  // Read request bookkeeping; any other finished frame cancels it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      read_pending <= 1'b0;
    end else if (link.frame_done) begin
      read_pending <= accept && !is_write && hits_reg;
    end
  end

  // Discard report for any frame not accepted: wrong length, or a needed or supplied CRC that fails
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      crc_reject_o <= 1'b0;
    end else begin
      crc_reject_o <= link.frame_done && !accept;
    end
  end

  // CRC of an outgoing word, most significant bit first
  function automatic logic [7:0] word_crc(input logic [15:0] w);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = apcr_crc_step(c, w[i], CRC_POLY);
    end
    word_crc = c;
  endfunction

  // Output shifters: load at frame start, advance on serial clock fall
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      shift_a <= '0;
      shift_b <= '0;
    end else if (link.cs_fall) begin
      if (read_pending) begin
        shift_a <= {readback, cfg[BIT_CRC_OUT] ? word_crc(readback) : 8'h00};
      end else begin
        shift_a <= {conv_a_i, cfg[BIT_CRC_OUT] ? word_crc(conv_a_i) : 8'h00};
      end
      shift_b <= {conv_b_i, cfg[BIT_CRC_OUT] ? word_crc(conv_b_i) : 8'h00};
    end else if (link.sclk_fall) begin
      shift_a <= {shift_a[22:0], 1'b0};
      shift_b <= {shift_b[22:0], 1'b0};
    end
  end

  // Serial outputs are the shifter heads
  assign first_data_output_o      = shift_a[23];
  assign second_output_or_alert_o = shift_b[23];

  // Pair for the conversion that is starting now
  always_comb begin
    if (cfg[BIT_SEQ]) begin
      next_pair = !pair_select_o;
    end else begin
      next_pair = cfg[BIT_PAIR];
    end
  end

  // Conversion settings, applied only at a conversion start
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pair_select_o      <= 1'b0;
      sequencer_active_o <= 1'b0;
      averaging_style_o  <= 1'b0;
      averaging_ratio_o  <= '0;
      oversample_on_o    <= 1'b0;
    end else if (link.cs_fall) begin
      pair_select_o      <= next_pair;
      sequencer_active_o <= cfg[BIT_SEQ];
      averaging_style_o  <= cfg[BIT_STYLE];
      averaging_ratio_o  <= cfg[RATIO_HI:RATIO_LO];
      oversample_on_o    <= cfg[RATIO_HI:RATIO_LO] >= RATIO_MIN_ON
                            && cfg[RATIO_HI:RATIO_LO] <= RATIO_MAX_ON;
    end
  end

  // CRC enables and conversion start strobe
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      in_crc_enable_o  <= 1'b0;
      out_crc_enable_o <= 1'b0;
      conv_start_o     <= 1'b0;
    end else begin
      in_crc_enable_o  <= cfg[BIT_CRC_IN];
      out_crc_enable_o <= cfg[BIT_CRC_OUT];
      conv_start_o     <= link.cs_fall;
    end
  end

  // Checks on the register, the serial paths and the conversion settings
  default clocking cb_top @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_reset_clears: assert property (disable iff (1'b0) sys_rst_i |=> cfg == 12'h000)
    else $error("register not zero after reset");

  a_write_loads: assert property (link.frame_done && accept && is_write && hits_reg
                                  |=> cfg == $past(link.frame_word[11:0]))
    else $error("accepted write did not load the register");

  a_bad_crc_drop: assert property (link.frame_done && !accept |=> $stable(cfg))
    else $error("rejected frame changed the register");

  a_crc_clear_guard: assert property (cfg[BIT_CRC_IN] && link.frame_done && !crc_good
                                      |=> cfg[BIT_CRC_IN])
    else $error("input CRC cleared without a valid CRC");

  a_crc_set_guard: assert property (!cfg[BIT_CRC_IN] && link.frame_done && !crc_good
                                    |=> !cfg[BIT_CRC_IN])
    else $error("input CRC set without a valid CRC");

  a_seq_alternate: assert property (link.cs_fall && cfg[BIT_SEQ]
                                    |=> pair_select_o != $past(pair_select_o))
    else $error("sequencer did not alternate the pair");

  a_pair_fixed: assert property (link.cs_fall && !cfg[BIT_SEQ]
                                 |=> pair_select_o == $past(cfg[BIT_PAIR]))
    else $error("pair select does not follow the register");

  a_settings_hold: assert property (!link.cs_fall |=> $stable(pair_select_o)
                                    && $stable(averaging_ratio_o)
                                    && $stable(averaging_style_o))
    else $error("settings changed outside a conversion start");

  a_ratio_decode: assert property (link.cs_fall |=> oversample_on_o ==
                                   (averaging_ratio_o inside {[3'h1:3'h5]}))
    else $error("ratio decode wrong");

  a_readback: assert property (link.cs_fall && read_pending
                               |=> shift_a[23:8] == $past(readback))
    else $error("read request not returned in the next frame");

  a_out_crc: assert property (link.cs_fall && !cfg[BIT_CRC_OUT]
                              |=> shift_a[7:0] == 8'h00 && shift_b[7:0] == 8'h00)
    else $error("output CRC present while disabled");

  c_write: cover property (link.frame_done && accept && is_write && hits_reg);
  c_read: cover property (link.cs_fall && read_pending);
  c_reject: cover property (crc_reject_o);
  c_seq: cover property (link.cs_fall && cfg[BIT_SEQ] ##[1:200] link.cs_fall);
endmodule

// *** verification/apcr_host_model.sv ***
// Host side of the serial link: drives frames and samples both data outputs.
// Assumes mclk_i is the bench clock; every serial level is held at least 8 cycles.
`timescale 1ns/10ps
module apcr_host_model (
  input  wire logic mclk_i,
  input  wire logic first_data_output_i,
  input  wire logic second_output_or_alert_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  localparam int HALF = 8; // Cycles per serial level, above the 6-cycle minimum

  // Idle: frame deselected, serial clock parked low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // Wait n bench cycles, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // One frame of nbits sent MSB first; returns what both outputs showed
  task automatic frame(input logic [23:0] word, input int nbits,
                       output logic [23:0] rd_a, output logic [23:0] rd_b);
    rd_a = 24'h000000;
    rd_b = 24'h000000;
    tick(1);
    cs_n_o = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi_o = word[i];
      tick(HALF);
      rd_a = {rd_a[22:0], first_data_output_i};
      rd_b = {rd_b[22:0], second_output_or_alert_i};
      sclk_o = 1'b1;
      tick(HALF);
      sclk_o = 1'b0;
    end
    tick(HALF);
    cs_n_o = 1'b1;
    sdi_o  = ~sdi_o; // Released line shows the inverse, not the last bit
    tick(2 * HALF);
  endtask
endmodule

// *** verification/tb.sv ***
// Self-checking bench: register access through serial frames of a host model.
// Assumes the design's package and interface are compiled first.
`timescale 1ns/10ps
module tb;
  import apcr_pkg::*;
  logic        mclk_i = 1'b0;  // Bench clock
  logic        sys_rst_i;       // Synchronous reset
  logic        sclk, cs_n, sdi; // Serial pins from the host model
  logic [15:0] conv_a, conv_b;  // Conversion words
  logic        dout_a, dout_b;  // Serial outputs
  logic        pair_sel, seq_act, style, os_on, crc_in_en, crc_out_en;
  logic [2:0]  ratio;           // Latched ratio code
  logic        conv_start, crc_rej;
  logic [23:0] ra, rb;          // Bits seen in the last frame
  logic [11:0] cfg;             // Expected register contents
  logic        got_rej;         // Last frame was discarded
  logic        p;               // Pair before a sequencer step
  int          errors = 0;
  int          n_checks = 0;
  int          n_rej = 0;       // Discard pulses seen
  int          n_conv = 0;      // Conversion starts seen

  always #5 mclk_i = ~mclk_i;

  // Count one-cycle pulses of the design
  always @(posedge mclk_i) begin
    if (crc_rej === 1'b1) n_rej++;
    if (conv_start === 1'b1) n_conv++;
  end

  apcr_host_model i_host (
    .mclk_i                   (mclk_i),
    .first_data_output_i      (dout_a),
    .second_output_or_alert_i (dout_b),
    .sclk_o                   (sclk),
    .cs_n_o                   (cs_n),
    .sdi_o                    (sdi)
  );

  apcr_top i_dut (
    .mclk_i                   (mclk_i),
    .sys_rst_i                (sys_rst_i),
    .sclk_i                   (sclk),
    .cs_n_i                   (cs_n),
    .sdi_i                    (sdi),
    .conv_a_i                 (conv_a),
    .conv_b_i                 (conv_b),
    .first_data_output_o      (dout_a),
    .second_output_or_alert_o (dout_b),
    .pair_select_o            (pair_sel),
    .sequencer_active_o       (seq_act),
    .averaging_style_o        (style),
    .averaging_ratio_o        (ratio),
    .oversample_on_o          (os_on),
    .in_crc_enable_o          (crc_in_en),
    .out_crc_enable_o         (crc_out_en),
    .conv_start_o             (conv_start),
    .crc_reject_o             (crc_rej)
  );

  // Frame CRC: 8 bits, MSB first, zero seed, no final inversion
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY_DEF : 8'h00);
    return c;
  endfunction

  // Compare and count
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Closing report, the only end of the run
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One frame; 24 bits carry a CRC, spoiled by xor with bad
  task automatic xfer(input logic [15:0] w, input int nb, input logic [7:0] bad);
    int r0;
    r0 = n_rej;
    i_host.frame((nb == 24) ? {w, crc8(w) ^ bad} : {8'h00, w}, nb, ra, rb);
    got_rej = (n_rej != r0);
  endtask

  // Register write with the expected accept or discard
  task automatic wr(input logic [11:0] d, input int nb, input logic [7:0] bad);
    logic ok;
    ok = (nb == 24 && bad == 8'h00) || (nb == 16 && !cfg[5] && !d[5]);
    xfer({4'h9, d}, nb, bad);
    check("reject", {23'h0, got_rej}, {23'h0, !ok});
    if (ok) cfg = d;
    check("crc_in_en", {23'h0, crc_in_en}, {23'h0, cfg[5]});
    check("crc_out_en", {23'h0, crc_out_en}, {23'h0, cfg[4]});
  endtask

  // Read request with junk data, then capture the word in the next frame
  task automatic readback();
    logic [15:0] e;
    e = {4'h1, cfg};
    xfer(16'h1FFF, 24, 8'h00);
    xfer(16'h0000, 24, 8'h00);
    check("readback", ra, {e, cfg[4] ? crc8(e) : 8'h00});
  endtask

  // Settings latched at the last conversion start
  task automatic chk_set(input logic pair);
    check("pair", {23'h0, pair_sel}, {23'h0, pair});
    check("seq", {23'h0, seq_act}, {23'h0, cfg[10]});
    check("style", {23'h0, style}, {23'h0, cfg[9]});
    check("ratio", {21'h0, ratio}, {21'h0, cfg[8:6]});
    check("os_on", {23'h0, os_on}, {23'h0, cfg[8:6] inside {[3'h1:3'h5]}});
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge mclk_i);
    errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    conv_a    = 16'hC3A5;
    conv_b    = 16'h5A3C;
    cfg       = 12'h000;
    repeat (3) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    check("idle", {16'h0, pair_sel, seq_act, style, ratio, os_on, crc_in_en}, 24'h0);
    readback();
    // New settings wait for the next conversion start
    wr(12'hAD0, 16, 8'h00);
    check("pair_held", {23'h0, pair_sel}, 24'h0);
    xfer(16'h0000, 24, 8'h00);
    chk_set(1'b1);
    readback();
    // Frame after a read of an empty address carries conversion words
    xfer(16'h0000, 24, 8'h00);
    check("conv_a", {8'h0, ra[23:8]}, {8'h0, conv_a});
    check("conv_b", {8'h0, rb[23:8]}, {8'h0, conv_b});
    xfer({4'hA, 12'hFFF}, 16, 8'h00);
    readback();
    // Every ratio code; rolling style only with ratios up to 8x
    for (int k = 0; k < 8; k++) begin
      wr({k[0], 1'b0, k inside {[1:3]}, k[2:0], 6'h00}, 16, 8'h00);
      p = n_conv[0];
      xfer(16'h0000, 24, 8'h00);
      check("conv_start", {23'h0, n_conv[0]}, {23'h0, !p});
      chk_set(k[0]);
    end
    // Sequencer alternates the pair at each conversion start
    wr(12'h400, 16, 8'h00);
    for (int j = 0; j < 4; j++) begin
      p = pair_sel;
      xfer(16'h0000, 24, 8'h00);
      check("seq_pair", {23'h0, pair_sel}, {23'h0, !p});
      check("seq_on", {23'h0, seq_act}, 24'h1);
    end
    // Input CRC enable: set and clear only with a valid CRC
    wr(12'h020, 16, 8'h00);
    wr(12'h020, 24, 8'h00);
    wr(12'h000, 16, 8'h00);
    wr(12'h000, 24, 8'h01);
    readback();
    wr(12'h000, 24, 8'h00);
    // A frame of the wrong length is dropped
    xfer({4'h9, 12'hAD0}, 15, 8'h00);
    check("short", {23'h0, got_rej}, 24'h1);
    readback();
    // Reset in mid-run clears the register
    wr(12'hAD0, 16, 8'h00);
    sys_rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    cfg = 12'h000;
    readback();
    give_verdict();
  end
endmodule
